// [swt_supervision_timer.sv]
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "swt_params.svh"
`default_nettype none

// Operation
// - An enabled timer requests a system reset when no restart comes before the time-out.
// - An optional early-warning flag is raised ahead of the time-out.
// - Windowed mode accepts a restart only in the open slot; one outside it resets the system.
// - Once enabled the count stops only when the enable is cleared, whatever sleep state the system is in.
// - The count advances on an oscillator tick divided by 10 from the bus clock aclk.
// - The reset request and the warning are registered on the bus clock aclk.
// - In normal mode the time-out is selectable from 8 to 16,384 oscillator cycles.
// - In windowed mode the total time-out is selectable from 16 to 32,768 oscillator cycles.
// - Writing the key 0xA5 to the restart register begins a fresh time-out period.
// - Writing any other value to the low byte of the restart register requests an immediate system reset.
// - Period, window and early-warning settings take writes only while the timer is disabled.
// - The timer cannot be disabled while the lock setting is on.
module swt_supervision_timer
  import swt_pkg::*;
(
  input wire logic aclk,  // Bus and timer clock.
  input wire logic aresetn,  // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr,  // Write address.
  input wire logic s_axi_awvalid,  // Write address valid.
  output logic s_axi_awready,  // Write address ready.
  input wire logic [31:0] s_axi_wdata,  // Write data.
  input wire logic [3:0] s_axi_wstrb,  // Write byte strobes.
  input wire logic s_axi_wvalid,  // Write data valid.
  output logic s_axi_wready,  // Write data ready.
  output logic [1:0] s_axi_bresp,  // Write response.
  output logic s_axi_bvalid,  // Write response valid.
  input wire logic s_axi_bready,  // Write response ready.
  input wire logic [7:0] s_axi_araddr,  // Read address.
  input wire logic s_axi_arvalid,  // Read address valid.
  output logic s_axi_arready,  // Read address ready.
  output logic [31:0] s_axi_rdata,  // Read data.
  output logic [1:0] s_axi_rresp,  // Read response.
  output logic s_axi_rvalid,  // Read data valid.
  input wire logic s_axi_rready,  // Read data ready.
  output logic sys_reset_req,  // One-cycle system reset request.
  output logic early_warning,  // Early-warning level, flag gated by its enable.
  output logic timer_running  // High while the timer is enabled.
);

  // Length in oscillator cycles for a 4-bit select; selects above the top clamp to it.
  function automatic logic [15:0] swt_len(input logic [3:0] sel);
    logic [15:0] len;
    len = `SWT_LEN_MIN;
    if (sel >= `SWT_SEL_MAX) begin
      len = `SWT_LEN_MAX;
    end else begin
      len = `SWT_LEN_MIN << sel;
    end
    return len;
  endfunction

  // Bus slave state.
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // Timer state.
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [3:0] timeout_period_select_ff, nxt_timeout_period_select;
  logic [3:0] window_select_ff, nxt_window_select;
  logic [3:0] ew_offset_ff, nxt_ew_offset;
  logic [15:0] count_ff, nxt_count;
  logic [3:0] div_ff, nxt_div;
  swt_phase_t phase_ff, nxt_phase;
  logic ew_flag_ff, nxt_ew_flag;
  logic reset_ff, nxt_reset;

  logic do_write;
  logic wr_lane0;
  logic osc_tick;
  logic enabled;
  logic windowed_mode_on;
  logic cannot_disable_lock;
  logic [15:0] per_len;
  logic [15:0] win_len;
  logic [15:0] total_len;
  logic [15:0] ew_len;

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane0 = do_write && wstrb_ff[0];
  assign enabled = ctrl_ff[`SWT_CTRL_ENABLE];
  assign windowed_mode_on = ctrl_ff[`SWT_CTRL_WINDOWED];
  assign cannot_disable_lock = ctrl_ff[`SWT_CTRL_LOCK];
  assign per_len = swt_len(timeout_period_select_ff);
  assign win_len = swt_len(window_select_ff);
  assign total_len = windowed_mode_on ? 16'(win_len + per_len) : per_len;
  assign ew_len = swt_len(ew_offset_ff);
  assign osc_tick = (div_ff == 4'(`SWT_OSC_DIV - 1));

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign sys_reset_req = reset_ff;
  assign early_warning = ew_flag_ff && ctrl_ff[`SWT_CTRL_EW_IE];
  assign timer_running = enabled;

  // Bus slave: address and data are taken in either order, then answered.
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      case (awaddr_ff)
        `SWT_OFS_CTRL, `SWT_OFS_CONFIG, `SWT_OFS_EWCTRL, `SWT_OFS_RESTART,
        `SWT_OFS_STATUS, `SWT_OFS_COUNT: begin
          nxt_bresp = `SWT_RESP_OKAY;
        end
        default: begin
          nxt_bresp = `SWT_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `SWT_RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `SWT_OFS_CTRL: begin
          nxt_rdata = {28'h000_0000, ctrl_ff};
        end
        `SWT_OFS_CONFIG: begin
          nxt_rdata = {24'h00_0000, window_select_ff, timeout_period_select_ff};
        end
        `SWT_OFS_EWCTRL: begin
          nxt_rdata = {28'h000_0000, ew_offset_ff};
        end
        `SWT_OFS_RESTART: begin
          nxt_rdata = 32'h0000_0000;
        end
        `SWT_OFS_STATUS: begin
          nxt_rdata = {29'h0000_0000, enabled, phase_ff == SWT_ST_OPEN, ew_flag_ff};
        end
        `SWT_OFS_COUNT: begin
          nxt_rdata = {16'h0000, count_ff};
        end
        default: begin
          nxt_rresp = `SWT_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'b00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Timer: settings, oscillator divider, count, window phase and reset request.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_timeout_period_select = timeout_period_select_ff;
    nxt_window_select = window_select_ff;
    nxt_ew_offset = ew_offset_ff;
    nxt_count = count_ff;
    nxt_phase = phase_ff;
    nxt_ew_flag = ew_flag_ff;
    nxt_reset = 1'b0;
    // The tick runs free of any sleep or clock-gating input.
    nxt_div = osc_tick ? 4'h0 : 4'(div_ff + 4'h1);

    // Counting has no sleep qualifier: only the enable stops it.
    if (enabled && osc_tick) begin
      nxt_count = 16'(count_ff + 16'h0001);
      if (nxt_count >= total_len) begin
        nxt_reset = 1'b1;
        nxt_count = 16'h0000;
        nxt_phase = windowed_mode_on ? SWT_ST_CLOSED : SWT_ST_OPEN;
      end else if (windowed_mode_on && nxt_count == win_len) begin
        nxt_phase = SWT_ST_OPEN;
        nxt_ew_flag = 1'b1;
      end else if (!windowed_mode_on && nxt_count == ew_len) begin
        nxt_ew_flag = 1'b1;
      end
    end

    if (wr_lane0) begin
      case (awaddr_ff)
        `SWT_OFS_CTRL: begin
          if (!enabled) begin
            nxt_ctrl = wdata_ff[3:0];
            if (wdata_ff[`SWT_CTRL_ENABLE]) begin
              nxt_count = 16'h0000;
              nxt_div = 4'h0;
              nxt_ew_flag = 1'b0;
              nxt_phase = wdata_ff[`SWT_CTRL_WINDOWED] ? SWT_ST_CLOSED : SWT_ST_OPEN;
            end
          end else if (!wdata_ff[`SWT_CTRL_ENABLE] && !cannot_disable_lock) begin
            nxt_ctrl[`SWT_CTRL_ENABLE] = 1'b0;
            nxt_phase = SWT_ST_STOP;
          end
        end
        `SWT_OFS_CONFIG: begin
          if (!enabled) begin
            nxt_timeout_period_select = wdata_ff[`SWT_CFG_PER_LSB +: 4];
            nxt_window_select = wdata_ff[`SWT_CFG_WIN_LSB +: 4];
          end
        end
        `SWT_OFS_EWCTRL: begin
          if (!enabled) begin
            nxt_ew_offset = wdata_ff[3:0];
          end
        end
        `SWT_OFS_RESTART: begin
          if (enabled) begin
            if (wdata_ff[7:0] != `SWT_KEY) begin
              nxt_reset = 1'b1;
            end else if (phase_ff == SWT_ST_CLOSED) begin
              nxt_reset = 1'b1;
            end
            nxt_count = 16'h0000;
            nxt_div = 4'h0;
            nxt_phase = windowed_mode_on ? SWT_ST_CLOSED : SWT_ST_OPEN;
          end
        end
        `SWT_OFS_STATUS: begin
          // A new warning in this cycle wins over the clear.
          if (wdata_ff[`SWT_STAT_EW] && !(nxt_ew_flag && !ew_flag_ff)) begin
            nxt_ew_flag = 1'b0;
          end
        end
        default: begin
          nxt_ctrl = nxt_ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `SWT_CTRL_RST;
      timeout_period_select_ff <= `SWT_SEL_RST;
      window_select_ff <= `SWT_SEL_RST;
      ew_offset_ff <= `SWT_EWOFS_RST;
      count_ff <= 16'h0000;
      div_ff <= 4'h0;
      phase_ff <= SWT_ST_STOP;
      ew_flag_ff <= 1'b0;
      reset_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      timeout_period_select_ff <= nxt_timeout_period_select;
      window_select_ff <= nxt_window_select;
      ew_offset_ff <= nxt_ew_offset;
      count_ff <= nxt_count;
      div_ff <= nxt_div;
      phase_ff <= nxt_phase;
      ew_flag_ff <= nxt_ew_flag;
      reset_ff <= nxt_reset;
    end
  end

endmodule
`default_nettype wire

// [swt_params.svh]
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define SWT_OFS_CTRL 8'h00
`define SWT_OFS_CONFIG 8'h04
`define SWT_OFS_EWCTRL 8'h08
`define SWT_OFS_RESTART 8'h0C
`define SWT_OFS_STATUS 8'h10
`define SWT_OFS_COUNT 8'h14

// Control register fields.
`define SWT_CTRL_ENABLE 0
`define SWT_CTRL_WINDOWED 1
`define SWT_CTRL_LOCK 2
`define SWT_CTRL_EW_IE 3

// Configuration fields: period select in [3:0], closed-window select in [7:4].
`define SWT_CFG_PER_LSB 0
`define SWT_CFG_WIN_LSB 4

// Status fields.
`define SWT_STAT_EW 0
`define SWT_STAT_OPEN 1
`define SWT_STAT_RUN 2

// Reset values.
`define SWT_CTRL_RST 4'h0
`define SWT_SEL_RST 4'hB
`define SWT_EWOFS_RST 4'hA

// Restart key and length table limits, in oscillator cycles.
`define SWT_KEY 8'hA5
`define SWT_LEN_MIN 16'h0008
`define SWT_LEN_MAX 16'h4000
`define SWT_SEL_MAX 4'hB

// Oscillator tick derived from the 10 MHz bus clock.
`define SWT_CLK_PERIOD_NS 100
`define SWT_OSC_PERIOD_NS 1000
`define SWT_OSC_DIV (`SWT_OSC_PERIOD_NS / `SWT_CLK_PERIOD_NS)

`define SWT_RESP_OKAY 2'b00
`define SWT_RESP_SLVERR 2'b10

`endif

// [swt_pkg.sv]
`default_nettype none
package swt_pkg;
  typedef enum logic [2:0] {
    SWT_ST_STOP = 3'b001,
    SWT_ST_CLOSED = 3'b010,
    SWT_ST_OPEN = 3'b100
  } swt_phase_t;
endpackage
`default_nettype wire

// [swt_supervision_timer_props.sv]
`default_nettype none
module swt_props (
  input wire logic aclk,  // Clock.
  input wire logic aresetn,  // Reset, active low.
  input wire logic s_axi_awvalid,  // AW valid.
  input wire logic s_axi_awready,  // AW ready.
  input wire logic s_axi_wvalid,  // W valid.
  input wire logic s_axi_wready,  // W ready.
  input wire logic s_axi_bvalid,  // B valid.
  input wire logic s_axi_bready,  // B ready.
  input wire logic s_axi_arvalid,  // AR valid.
  input wire logic s_axi_arready,  // AR ready.
  input wire logic s_axi_rvalid,  // R valid.
  input wire logic s_axi_rready,  // R ready.
  input wire logic sys_reset_req,  // Reset pulse.
  input wire logic timer_running  // Enabled.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_r_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_b_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_r_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_pulse_once: assert property ($rose(sys_reset_req) |=> !sys_reset_req)
    else $error("reset request wider than one cycle");
  a_pulse_running: assert property (sys_reset_req |-> $past(timer_running))
    else $error("reset request from a stopped timer");
  a_enable_quiet: assert property ($rose(timer_running) |-> !sys_reset_req [*4])
    else $error("reset request right after enable");
endmodule
bind swt_supervision_timer swt_props i_swt_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sys_reset_req,
  .timer_running);
`default_nettype wire

// [tb_swt_supervision_timer.sv]
`include "swt_params.svh"
`default_nettype none
module tb_swt_supervision_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rst_req, warn, running;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int n_fail = 0, n_tests = 0, n_rst = 0, r0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (rst_req === 1'b1) n_rst <= n_rst + 1;
  swt_supervision_timer i_swt_supervision_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sys_reset_req(rst_req), .early_warning(warn), .timer_running(running));
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic lost(input int k);
    if (k == 20) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    lost(k);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    lost(k);
  endtask
  task automatic t_reset_vals();
    rdr(`SWT_OFS_CTRL, rd, resp);
    chk(rd, 32'h0000_0000);
    rdr(`SWT_OFS_CONFIG, rd, resp);
    chk(rd, 32'h0000_00BB);
    rdr(8'h18, rd, resp);
    chk({30'h0, resp}, {30'h0, `SWT_RESP_SLVERR});
    wr(8'h18, 32'h0000_0001, resp);
    chk({30'h0, resp}, {30'h0, `SWT_RESP_SLVERR});
  endtask
  // Period of 8 ticks, restarts kept well inside it, then a missed restart.
  task automatic t_normal();
    wr(`SWT_OFS_CONFIG, 32'h0000_0000, resp);
    chk({30'h0, resp}, {30'h0, `SWT_RESP_OKAY});
    wr(`SWT_OFS_CTRL, 32'h0000_0001, resp);
    r0 = n_rst;
    repeat (4) begin
      repeat (45) @(posedge aclk);
      wr(`SWT_OFS_RESTART, {24'h00_0000, `SWT_KEY}, resp);
    end
    chk(n_rst, r0);
    wr(`SWT_OFS_CONFIG, 32'h0000_0033, resp);
    rdr(`SWT_OFS_CONFIG, rd, resp);
    chk(rd, 32'h0000_0000);
    wr(`SWT_OFS_RESTART, {24'h00_0000, `SWT_KEY}, resp);
    r0 = n_rst;
    repeat (75) @(posedge aclk);
    chk(n_rst, r0);
    repeat (10) @(posedge aclk);
    chk(n_rst, r0 + 1);
    r0 = n_rst;
    wr(`SWT_OFS_RESTART, 32'h0000_0012, resp);
    repeat (2) @(posedge aclk);
    chk(n_rst, r0 + 1);
    wr(`SWT_OFS_CTRL, 32'h0000_0000, resp);
    chk({31'h0, running}, 32'h0000_0000);
  endtask
  // Closed slot of 16 ticks, open slot of 8, warning enabled and lock set.
  task automatic t_window();
    wr(`SWT_OFS_CONFIG, 32'h0000_0010, resp);
    wr(`SWT_OFS_CTRL, 32'h0000_000F, resp);
    r0 = n_rst;
    wr(`SWT_OFS_RESTART, {24'h00_0000, `SWT_KEY}, resp);
    repeat (2) @(posedge aclk);
    chk(n_rst, r0 + 1);
    repeat (150) @(posedge aclk);
    chk({31'h0, warn}, 32'h0000_0000);
    repeat (20) @(posedge aclk);
    chk({31'h0, warn}, 32'h0000_0001);
    r0 = n_rst;
    wr(`SWT_OFS_RESTART, {24'h00_0000, `SWT_KEY}, resp);
    wr(`SWT_OFS_CTRL, 32'h0000_0000, resp);
    chk({31'h0, running}, 32'h0000_0001);
    repeat (225) @(posedge aclk);
    chk(n_rst, r0);
    repeat (20) @(posedge aclk);
    chk(n_rst, r0 + 1);
    wr(`SWT_OFS_STATUS, 32'h0000_0001, resp);
    chk({31'h0, warn}, 32'h0000_0000);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_normal();
    t_window();
    print_verdict();
  end
endmodule
`default_nettype wire
